/* swpbc_pkg.sv */
// Purpose: Shared constants and types of the serial width, pin and rate configuration block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   Register byte address is four times the register index
package swpbc_pkg;

	// ****************************************
	// Register indices
	// ****************************************
	localparam logic [2:0] IDX_CTRL_ONE   = 3'h0;
	localparam logic [2:0] IDX_CTRL_TWO   = 3'h1;
	localparam logic [2:0] IDX_RATE       = 3'h2;
	localparam logic [2:0] IDX_STATUS     = 3'h3;
	localparam logic [2:0] IDX_DATA       = 3'h4;
	localparam logic [2:0] IDX_IRQ_CLEAR  = 3'h6;
	localparam logic [2:0] IDX_IRQ_ENABLE = 3'h7;

	// ****************************************
	// Field positions, masks and reset values
	// ****************************************
	localparam int unsigned ONE_ENABLE_BIT  = 6;
	localparam int unsigned ONE_MASTER_BIT  = 4;
	localparam int unsigned ONE_SEL_OE_BIT  = 1;
	localparam int unsigned TWO_WIDTH_BIT   = 6;
	localparam int unsigned TWO_MODE_FAULT_FLAG_EN_BIT = 4;
	localparam int unsigned TWO_BIDIR_OE    = 3;
	localparam int unsigned TWO_WAIT_STOP   = 1;
	localparam int unsigned TWO_PIN_CTRL    = 0;
	localparam int unsigned RATE_PRE_LSB    = 4;
	localparam int unsigned RATE_DIV_LSB    = 0;
	localparam int unsigned STATUS_BUSY_BIT = 7;
	localparam logic [7:0] ONE_MASK   = 8'h52;
	localparam logic [7:0] TWO_MASK   = 8'h5b;
	localparam logic [7:0] TWO_ABORT  = 8'h51;
	localparam logic [7:0] RATE_MASK  = 8'h77;
	localparam logic [7:0] ONE_RESET  = 8'h00;
	localparam logic [7:0] TWO_RESET  = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h00;

	// Event bits of status, clear and enable registers
	localparam int unsigned EV_DONE  = 0;
	localparam int unsigned EV_FAULT = 1;
	localparam int unsigned EV_ABORT = 2;
	localparam int unsigned EV_W     = 3;

	// Transfer widths in bits
	localparam logic [4:0] WIDTH_NARROW = 5'h08;
	localparam logic [4:0] WIDTH_WIDE   = 5'h10;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic o;
		logic oe;
	} swpbc_pin_t;

	typedef enum logic {ST_IDLE, ST_RUN} swpbc_state_t;

	// Half serial clock period in bus cycles: divisor (pre+1)*2^(div+1) over two
	function automatic logic [10:0] swpbc_half(input logic [2:0] pre, input logic [2:0] div);
		swpbc_half = 11'((11'(pre) + 11'h001) << div);
	endfunction : swpbc_half

endpackage : swpbc_pkg

/* swpbc_top.sv */
// Purpose: Width select, pin configuration and serial clock rate of a serial unit
// Assumes: hclk 250 MHz, hresetn asynchronous active low, AHB-Lite slave
// Notes:   Mode 0 framing, MSB first; events interrupt through status/enable
// Overview of operation
// - Width bit picks 8 or 16 bit data
// - Master: width, fault, pin, rate change aborts
// - Master bidir: output enable change aborts transfer
// - Master without fault enable ignores select pin
// - Fault enable without select enable senses select pin for faults
// - Slave: select pin is input only
// - Bidir output enable gates the data driver
// - Wait stop bit halts clock in wait
// - Normal mode uses both data pins
// - Bidir master uses MOSI only
// - Bidir slave uses MISO only
// - Divisor is (pre+1) times 2^(div+1)
// - Serial rate is bus clock over divisor
// - Registers read/write anytime, reserved bits ignored
// - Fault and select enable drive select pin
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module swpbc_top #(
	parameter int unsigned FIELD_W = 3
) (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic               wait_mode,
	input  wire logic               sck_i,
	input  wire logic               mosi_i,
	input  wire logic               miso_i,
	input  wire logic               ss_n_i,
	output swpbc_pkg::swpbc_pin_t   sck,
	output swpbc_pkg::swpbc_pin_t   mosi,
	output swpbc_pkg::swpbc_pin_t   miso,
	output swpbc_pkg::swpbc_pin_t   ss_n,
	output logic                    irq
);

	// Prescaler and rate fields are fixed at three bits
	if (FIELD_W != 3) begin : g_bad_field
		$error("FIELD_W must be 3");
	end

	// ****************************************
	// Declarations
	// ****************************************
	logic [7:0]                  one_reg, two_reg, rate_reg;
	logic [15:0]                 tx_reg, rx_reg, sh_reg;
	logic [swpbc_pkg::EV_W-1:0]  status_reg, irq_en_reg, ev;
	swpbc_pkg::swpbc_state_t     state_reg;
	logic [3:0]                  s1_reg, s2_reg, s3_reg, filt_reg;
	logic                        sck_d_reg, sck_lvl_reg, rx_bit_reg;
	logic [10:0]                 div_cnt_reg;
	logic [4:0]                  bit_cnt_reg;
	logic                        dp_valid_reg, dp_write_reg, dp_map_reg;
	logic [2:0]                  dp_idx_reg;
	logic                        ap_valid, wr, run, enable, master, sel_oe;
	logic                        wide, mode_fault_flag_en, bidir_oe, wait_stop, pin_ctrl;
	logic                        sck_f, mosi_f, miso_f, ss_f;
	logic                        wr_one, wr_two, wr_rate, wr_data, cfg_abort, fault;
	logic                        div_en, tick, lead, trail, start_m, start_s, last_bit;
	logic                        slave_quit, stop;
	logic [7:0]                  two_new, rate_new, one_new;
	logic [4:0]                  width_n;
	logic [10:0]                 half;
	logic                        rx_src;

	// ****************************************
	// Field decode
	// ****************************************
	assign enable    = one_reg[swpbc_pkg::ONE_ENABLE_BIT];
	assign master    = one_reg[swpbc_pkg::ONE_MASTER_BIT];
	assign sel_oe    = one_reg[swpbc_pkg::ONE_SEL_OE_BIT];
	assign wide      = two_reg[swpbc_pkg::TWO_WIDTH_BIT];
	assign mode_fault_flag_en   = two_reg[swpbc_pkg::TWO_MODE_FAULT_FLAG_EN_BIT];
	assign bidir_oe  = two_reg[swpbc_pkg::TWO_BIDIR_OE];
	assign wait_stop = two_reg[swpbc_pkg::TWO_WAIT_STOP];
	assign pin_ctrl  = two_reg[swpbc_pkg::TWO_PIN_CTRL];
	assign width_n   = wide ? swpbc_pkg::WIDTH_WIDE : swpbc_pkg::WIDTH_NARROW;
	assign half      = swpbc_pkg::swpbc_half(rate_reg[swpbc_pkg::RATE_PRE_LSB +: FIELD_W],
		rate_reg[swpbc_pkg::RATE_DIV_LSB +: FIELD_W]);
	assign run       = (state_reg == swpbc_pkg::ST_RUN);
	assign {sck_f, mosi_f, miso_f, ss_f} = filt_reg;

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	assign ap_valid = hsel && hready && htrans[1];
	assign wr       = dp_valid_reg && dp_write_reg && dp_map_reg;
	assign wr_one   = wr && (dp_idx_reg == swpbc_pkg::IDX_CTRL_ONE);
	assign wr_two   = wr && (dp_idx_reg == swpbc_pkg::IDX_CTRL_TWO);
	assign wr_rate  = wr && (dp_idx_reg == swpbc_pkg::IDX_RATE);
	assign wr_data  = wr && (dp_idx_reg == swpbc_pkg::IDX_DATA);
	// Reserved positions keep their zero whatever is written
	assign one_new  = hwdata[7:0] & swpbc_pkg::ONE_MASK;
	assign two_new  = hwdata[7:0] & swpbc_pkg::TWO_MASK;
	assign rate_new = hwdata[7:0] & swpbc_pkg::RATE_MASK;

	// Address phase capture; zero wait states so hreadyout stays high
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_reg <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_map_reg   <= 1'b0;
			dp_idx_reg   <= 3'h0;
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
		end else begin
			dp_valid_reg <= ap_valid;
			dp_write_reg <= hwrite;
			dp_map_reg   <= (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'h0);
			dp_idx_reg   <= haddr[4:2];
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
		end
	end

	// Read data prepared at the address phase; unmapped reads return zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (ap_valid && !hwrite && haddr[31:5] == 27'h0 && haddr[1:0] == 2'h0) begin
			unique case (haddr[4:2])
				swpbc_pkg::IDX_CTRL_ONE:   hrdata <= {24'h0, one_reg};
				swpbc_pkg::IDX_CTRL_TWO:   hrdata <= {24'h0, two_reg};
				swpbc_pkg::IDX_RATE:       hrdata <= {24'h0, rate_reg};
				swpbc_pkg::IDX_STATUS:     hrdata <= {24'h0, run, 4'h0, status_reg};
				swpbc_pkg::IDX_DATA:       hrdata <= {16'h0, rx_reg};
				swpbc_pkg::IDX_IRQ_ENABLE: hrdata <= {29'h0, irq_en_reg};
				default:                   hrdata <= 32'h0;
			endcase
		end else begin
			hrdata <= 32'h0;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	// Mode fault drops master mode so two masters stop fighting
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			one_reg <= swpbc_pkg::ONE_RESET;
		end else if (fault) begin
			one_reg[swpbc_pkg::ONE_MASTER_BIT] <= 1'b0;
		end else if (wr_one) begin
			one_reg <= one_new;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			two_reg <= swpbc_pkg::TWO_RESET;
		end else if (wr_two) begin
			two_reg <= two_new;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rate_reg <= swpbc_pkg::RATE_RESET;
		end else if (wr_rate) begin
			rate_reg <= rate_new;
		end
	end

	// Changes that alter framing or pins while a master shifts abort it
	assign cfg_abort = master && (
		(wr_two && |((two_new ^ two_reg) & swpbc_pkg::TWO_ABORT)) ||
		(wr_two && pin_ctrl &&
			(two_new[swpbc_pkg::TWO_BIDIR_OE] != bidir_oe)) ||
		(wr_rate && (rate_new != rate_reg)) ||
		(wr_one && (one_new != one_reg)));

	// Select pin low with fault detection armed means another master
	assign fault = enable && master && mode_fault_flag_en && !sel_oe && !ss_f;

	// ****************************************
	// Pin input synchronisers
	// ****************************************
	// Three stages; a level counts once the last two agree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_reg   <= 4'h1;
			s2_reg   <= 4'h1;
			s3_reg   <= 4'h1;
			filt_reg <= 4'h1;
		end else begin
			s1_reg   <= {sck_i, mosi_i, miso_i, ss_n_i};
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
		end
	end

	// ****************************************
	// Serial clock divider
	// ****************************************
	// Counts only in a master transfer; wait stop freezes the count
	assign div_en = run && master && !(wait_stop && wait_mode);
	assign tick   = div_en && (div_cnt_reg == 11'h000);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_reg <= 11'h000;
		end else if (!run) begin
			div_cnt_reg <= half - 11'h001;
		end else if (tick) begin
			div_cnt_reg <= half - 11'h001;
		end else if (div_en) begin
			div_cnt_reg <= div_cnt_reg - 11'h001;
		end
	end

	// ****************************************
	// Transfer sequencing
	// ****************************************
	assign start_m    = wr_data && enable && master && !run && !cfg_abort;
	assign start_s    = enable && !master && !run && !ss_f;
	assign slave_quit = !master && ss_f;
	assign lead  = run && (master ? (tick && !sck_lvl_reg) : (sck_f && !sck_d_reg));
	assign trail = run && (master ? (tick && sck_lvl_reg) : (!sck_f && sck_d_reg));
	assign last_bit = trail && (bit_cnt_reg + 5'h01 == width_n);
	assign stop  = cfg_abort || fault || !enable || slave_quit;
	// Receive pin follows the pin configuration
	assign rx_src = master ? (pin_ctrl ? mosi_f : miso_f)
		: (pin_ctrl ? miso_f : mosi_f);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= swpbc_pkg::ST_IDLE;
		end else if (stop || last_bit) begin
			state_reg <= swpbc_pkg::ST_IDLE;
		end else if (start_m || start_s) begin
			state_reg <= swpbc_pkg::ST_RUN;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_cnt_reg <= 5'h00;
		end else if (!run) begin
			bit_cnt_reg <= 5'h00;
		end else if (trail) begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	// Narrow words sit in the top byte so bit 15 is always the next out
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sh_reg <= 16'h0;
		end else if (start_m) begin
			sh_reg <= wide ? hwdata[15:0] : {hwdata[7:0], 8'h00};
		end else if (start_s) begin
			sh_reg <= wide ? tx_reg : {tx_reg[7:0], 8'h00};
		end else if (trail) begin
			sh_reg <= {sh_reg[14:0], rx_bit_reg};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_bit_reg <= 1'b0;
			sck_d_reg  <= 1'b0;
		end else begin
			rx_bit_reg <= lead ? rx_src : rx_bit_reg;
			sck_d_reg  <= sck_f;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sck_lvl_reg <= 1'b0;
		end else if (!run) begin
			sck_lvl_reg <= 1'b0;
		end else if (tick) begin
			sck_lvl_reg <= !sck_lvl_reg;
		end
	end

	// Narrow mode reads back only the low byte
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_reg <= 16'h0;
			rx_reg <= 16'h0;
		end else begin
			if (wr_data) begin
				tx_reg <= wide ? hwdata[15:0] : {8'h00, hwdata[7:0]};
			end
			if (last_bit && !stop) begin
				rx_reg <= wide ? {sh_reg[14:0], rx_bit_reg} : {8'h00, sh_reg[6:0], rx_bit_reg};
			end
		end
	end

	// ****************************************
	// Events and interrupt
	// ****************************************
	assign ev[swpbc_pkg::EV_DONE]  = last_bit && !stop;
	assign ev[swpbc_pkg::EV_FAULT] = fault;
	assign ev[swpbc_pkg::EV_ABORT] = run && cfg_abort;

	// A new event wins over a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= '0;
		end else begin
			status_reg <= (status_reg &
				~((wr && dp_idx_reg == swpbc_pkg::IDX_IRQ_CLEAR) ? hwdata[2:0] : 3'h0)) | ev;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_en_reg <= '0;
			irq        <= 1'b0;
		end else begin
			if (wr && dp_idx_reg == swpbc_pkg::IDX_IRQ_ENABLE) begin
				irq_en_reg <= hwdata[2:0];
			end
			irq <= |(status_reg & irq_en_reg);
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sck  <= '0;
			mosi <= '0;
			miso <= '0;
			ss_n <= '{o: 1'b1, oe: 1'b0};
		end else begin
			sck.o   <= sck_lvl_reg;
			sck.oe  <= enable && master;
			mosi.o  <= sh_reg[15];
			mosi.oe <= enable && master && (!pin_ctrl || bidir_oe);
			miso.o  <= sh_reg[15];
			miso.oe <= enable && !master && !ss_f && (!pin_ctrl || bidir_oe);
			ss_n.o  <= !run;
			ss_n.oe <= enable && master && mode_fault_flag_en && sel_oe;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic [10:0] gap_reg;
	logic        seen_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap_reg  <= 11'h000;
			seen_reg <= 1'b0;
		end else begin
			gap_reg  <= tick ? 11'h000 : (div_en ? gap_reg + 11'h001 : gap_reg);
			seen_reg <= run && (seen_reg || tick);
		end
	end

	property p_narrow_load;
		(start_m && !wide) |=> (sh_reg[7:0] == 8'h00);
	endproperty
	a_narrow_load: assert property (p_narrow_load) else $error("narrow load not aligned");
	property p_cfg_abort;
		(run && master && wr_rate && rate_new != rate_reg) |=> !run;
	endproperty
	a_cfg_abort: assert property (p_cfg_abort) else $error("rate change kept running");
	// Only the next cycle: a back-to-back data write may legally restart right after
	property p_oe_abort;
		(run && master && pin_ctrl && wr_two && two_new[swpbc_pkg::TWO_BIDIR_OE] != bidir_oe)
			|=> !run;
	endproperty
	a_oe_abort: assert property (p_oe_abort) else $error("output enable change kept running");
	property p_ss_unused;
		ss_n.oe |-> $past(master) && $past(mode_fault_flag_en) && $past(sel_oe);
	endproperty
	a_ss_unused: assert property (p_ss_unused) else $error("select pin driven wrongly");
	property p_fault;
		(enable && master && mode_fault_flag_en && !sel_oe && !ss_f) |=> !master && status_reg[1];
	endproperty
	a_fault: assert property (p_fault) else $error("mode fault missed");
	property p_slave_ss;
		(!master && enable) |=> !ss_n.oe;
	endproperty
	a_slave_ss: assert property (p_slave_ss) else $error("slave drove select pin");
	property p_bidir_gate;
		(enable && master && pin_ctrl && !bidir_oe) |=> !mosi.oe && !miso.oe;
	endproperty
	a_bidir_gate: assert property (p_bidir_gate) else $error("bidir buffer not gated");
	property p_wait_stop;
		(wait_mode && wait_stop) |-> !tick;
	endproperty
	a_wait_stop: assert property (p_wait_stop) else $error("clock ran in wait stop");
	property p_normal_pins;
		(enable && master && !pin_ctrl) |=> mosi.oe && !miso.oe;
	endproperty
	a_normal_pins: assert property (p_normal_pins) else $error("normal master pins wrong");
	property p_half_period;
		(tick && seen_reg) |-> (gap_reg + 11'h001 == half);
	endproperty
	a_half_period: assert property (p_half_period) else $error("serial clock rate wrong");

endmodule : swpbc_top

/* swpbc_peer.sv */
// Purpose: Serial peer on the far side of the master link, mode 0, MSB first
// Assumes: Framed by the select line, shifted only by the master serial clock
// Notes:   A released data line toggles every bus cycle, so stale bits never match
`timescale 1ns/1ns
module swpbc_peer (
	input  wire logic        hclk,
	input  wire logic        sel_n,
	input  wire logic        sclk,
	input  wire logic        din,
	input  wire logic [15:0] tx_word,
	output logic             dout,
	output logic [15:0]      rx_word
);
	logic [15:0] shift_q;
	logic        last_q;
	// ****************************************
	// Frame handling
	// ****************************************
	// Reply is loaded as the frame opens
	always @(negedge sel_n) shift_q <= tx_word;
	// Next bit moves up on the falling edge
	always @(negedge sclk) shift_q <= {shift_q[14:0], 1'b0};
	// Master output is sampled on the rising edge
	always @(posedge sclk) rx_word <= {rx_word[14:0], din};
	// Outside a frame the line carries junk
	assign dout = sel_n ? ~last_q : shift_q[15];
	always @(posedge hclk) last_q <= dout;
endmodule : swpbc_peer

/* test_swpbc_top.sv */
// Purpose: Self-checking bench of the width, pin and rate configuration block
// Assumes: Single AHB-Lite master, zero wait states are not relied upon
// Notes:   Peer model answers on the data line; the bench drives the select pin
`timescale 1ns/1ns
module test_swpbc_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic wait_mode = 1'b0;
	logic ss_in = 1'b1;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic irq;
	swpbc_pkg::swpbc_pin_t sck;
	swpbc_pkg::swpbc_pin_t mosi;
	swpbc_pkg::swpbc_pin_t miso;
	swpbc_pkg::swpbc_pin_t ss_n;
	logic mosi_w;
	logic mosi_q = 1'b0;
	logic miso_w;
	logic peer_o;
	logic sck_w;
	logic [15:0] peer_tx = 16'h0;
	logic [15:0] peer_rx;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	// Abort table: address, start value, new value, abort expected
	localparam logic [7:0] AB_ADR [8] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h08, 8'h08};
	localparam logic [7:0] AB_BAS [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h33, 8'h33};
	localparam logic [7:0] AB_VAL [8] = '{8'h40, 8'h10, 8'h01, 8'h02, 8'h08, 8'h09, 8'h34, 8'h33};
	localparam logic [7:0] AB_EXP = 8'b01100111;

	always #2 hclk = ~hclk;
	// Undriven data lines toggle so the bench never sees a stale bit as good; an undriven clock line reads low
	assign mosi_w = mosi.oe ? mosi.o : ~mosi_q;
	assign miso_w = miso.oe ? miso.o : peer_o;
	assign sck_w = sck.oe ? sck.o : 1'b0;
	always @(posedge hclk) mosi_q <= mosi_w;

	swpbc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wait_mode(wait_mode),
		.sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .ss_n_i(ss_in), .sck(sck),
		.mosi(mosi), .miso(miso), .ss_n(ss_n), .irq(irq));
	swpbc_peer peer_u (.hclk(hclk), .sel_n(ss_n.o), .sclk(sck_w), .din(mosi_w),
		.tx_word(peer_tx), .dout(peer_o), .rx_word(peer_rx));

	// ****************************************
	// Bus and check helpers
	// ****************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask : chk

	// One single transfer; every signal held until hready is seen high
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus

	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task rd(input logic [31:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask : rd

	// Polls busy with a bound, so a hung transfer is reported, not waited on
	task wait_idle;
		logic [31:0] s;
		int n;
		n = 0;
		do begin
			rd(32'h0c, s);
			n++;
		end while (s[7] !== 1'b0 && n < 400);
		chk(32'(n < 400), 32'h1, "busy stuck");
	endtask : wait_idle

	// ****************************************
	// Scenarios
	// ****************************************
	task t_regs;
		logic [31:0] r;
		rd(32'h04, r);
		chk(r, 32'h0, "ctrl two reset");
		rd(32'h08, r);
		chk(r, 32'h0, "rate reset");
		wr(32'h04, 32'hffff_ffff);
		rd(32'h04, r);
		chk(r, 32'h5b, "ctrl two mask");
		wr(32'h08, 32'hffff_ffff);
		rd(32'h08, r);
		chk(r, 32'h77, "rate fields");
		rd(32'h40, r);
		chk(r, 32'h0, "unmapped read");
		rd(32'h05, r);
		chk({r[30:0], hresp}, 32'h0, "unaligned read okay");
		wr(32'h04, 32'h0);
		wr(32'h08, 32'h0);
		$display("test regs done");
	endtask : t_regs

	task t_xfer(input logic [7:0] two, input logic [15:0] d, input logic [15:0] rep);
		logic [31:0] r;
		logic [15:0] m;
		int n;
		m = two[6] ? 16'hffff : 16'h00ff;
		wr(32'h08, 32'h12);
		wr(32'h04, {24'h0, two});
		wr(32'h00, 32'h50);
		wr(32'h1c, 32'h1);
		peer_tx = two[6] ? rep : {rep[7:0], 8'h00};
		wr(32'h10, {16'hee00, d});
		n = 0;
		while (sck.o !== 1'b1 && n < 300) begin @(posedge hclk); n++; end
		n = 0;
		while (sck.o === 1'b1 && n < 300) begin @(posedge hclk); n++; end
		while (sck.o === 1'b0 && n < 300) begin @(posedge hclk); n++; end
		chk(n, 32'd16, "divisor");
		chk({sck.oe, mosi.oe, miso.oe}, 3'b110, "normal pins");
		wait_idle();
		rd(32'h10, r);
		chk(r, {16'h0, rep & m}, "rx word");
		chk(peer_rx & m, d & m, "tx word");
		chk(irq, 1'b1, "irq raised");
		wr(32'h1c, 32'h0);
		repeat (2) @(posedge hclk);
		chk(irq, 1'b0, "irq masked");
		wr(32'h1c, 32'h1);
		wr(32'h18, 32'h1);
		repeat (2) @(posedge hclk);
		chk(irq, 1'b0, "irq cleared");
		$display("test xfer %h done", two);
	endtask : t_xfer

	task t_abort;
		logic [31:0] s;
		for (int i = 0; i < 8; i++) begin
			wr(32'h04, AB_ADR[i] == 8'h08 ? 32'h0 : {24'h0, AB_BAS[i]});
			wr(32'h08, AB_ADR[i] == 8'h08 ? {24'h0, AB_BAS[i]} : 32'h33);
			wr(32'h00, 32'h50);
			wr(32'h18, 32'h7);
			wr(32'h10, 32'h5a);
			repeat (6) @(posedge hclk);
			wr({24'h0, AB_ADR[i]}, {24'h0, AB_VAL[i]});
			rd(32'h0c, s);
			chk({s[7], s[2]}, {!AB_EXP[i], AB_EXP[i]}, "abort");
			wr(32'h00, 32'h0);
		end
		$display("test abort done");
	endtask : t_abort

	task t_pins;
		logic [31:0] r;
		wr(32'h08, 32'h33);
		wr(32'h04, 32'h01);
		wr(32'h00, 32'h50);
		wr(32'h10, 32'h5a);
		repeat (6) @(posedge hclk);
		chk({mosi.oe, miso.oe}, 2'b00, "bidir in");
		wr(32'h00, 32'h0);
		wr(32'h04, 32'h09);
		wr(32'h00, 32'h50);
		wr(32'h10, 32'h5a);
		repeat (6) @(posedge hclk);
		chk({mosi.oe, miso.oe}, 2'b10, "bidir io");
		wr(32'h00, 32'h40);
		ss_in <= 1'b0;
		repeat (12) @(posedge hclk);
		chk({mosi.oe, miso.oe}, 2'b01, "slave io");
		ss_in <= 1'b1;
		wr(32'h04, 32'h10);
		wr(32'h00, 32'h52);
		repeat (2) @(posedge hclk);
		chk(ss_n.oe, 1'b1, "select out");
		wr(32'h00, 32'h42);
		repeat (2) @(posedge hclk);
		chk(ss_n.oe, 1'b0, "slave select in");
		wr(32'h18, 32'h7);
		wr(32'h00, 32'h50);
		ss_in <= 1'b0;
		repeat (12) @(posedge hclk);
		rd(32'h0c, r);
		chk(r[1], 1'b1, "mode fault");
		rd(32'h00, r);
		chk(r, 32'h40, "master dropped");
		ss_in <= 1'b1;
		wr(32'h18, 32'h7);
		wr(32'h04, 32'h0);
		wr(32'h00, 32'h52);
		repeat (2) @(posedge hclk);
		chk(ss_n.oe, 1'b0, "select unused");
		ss_in <= 1'b0;
		repeat (12) @(posedge hclk);
		rd(32'h0c, r);
		chk(r[1], 1'b0, "no fault");
		ss_in <= 1'b1;
		wr(32'h00, 32'h0);
		$display("test pins done");
	endtask : t_pins

	task t_wait;
		logic [31:0] r;
		logic moved;
		moved = 1'b0;
		wr(32'h08, 32'h12);
		wr(32'h04, 32'h02);
		wr(32'h00, 32'h50);
		wait_mode <= 1'b1;
		wr(32'h10, 32'h81);
		repeat (40) begin
			@(posedge hclk);
			moved = moved | (sck.o !== 1'b0);
		end
		rd(32'h0c, r);
		chk({moved, r[7]}, 2'b01, "clock held");
		wait_mode <= 1'b0;
		wait_idle();
		wr(32'h04, 32'h0);
		wait_mode <= 1'b1;
		wr(32'h10, 32'h81);
		wait_idle();
		wait_mode <= 1'b0;
		$display("test wait done");
	endtask : t_wait

	// ****************************************
	// Closing and main sequence
	// ****************************************
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	// Ceiling well above the 1200 or so cycles the scenarios need
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_xfer(8'h00, 16'h1ba5, 16'h003c);
		t_xfer(8'h40, 16'h1234, 16'hc3a5);
		t_abort();
		t_pins();
		t_wait();
		tally_and_finish();
	end
endmodule : test_swpbc_top
